// File: logic/fsk_modem_supervisory_control.sv
// Supervisory control of a low-speed FSK modem: call handshake and hang-up
module fsk_modem_supervisory_control
  import fsk_sup_pkg::*;
#(
  parameter logic [TW-1:0] RING_LOW_CYC   = TW'((CLK_HZ * T_RING_LOW_MS + 999) / 1000),
  parameter logic [TW-1:0] RING_PMIN_CYC  = TW'((CLK_HZ + RING_FMAX_HZ - 1) / RING_FMAX_HZ),
  parameter logic [TW-1:0] RING_PMAX_CYC  = TW'(CLK_HZ / RING_FMIN_HZ),
  parameter logic [TW-1:0] TD_LOSS_CYC    = TW'((CLK_HZ * T_TD_LOSS_MS + 999) / 1000),
  parameter logic [TW-1:0] UNCLAMP_CYC    = TW'((CLK_HZ * T_UNCLAMP_MS + 999) / 1000),
  parameter logic [TW-1:0] ANS_CTS_CYC    = TW'((CLK_HZ * T_ANS_CTS_MS + 999) / 1000),
  parameter logic [TW-1:0] ORG_TXON_CYC   = TW'((CLK_HZ * T_ORG_TXON_MS + 999) / 1000),
  parameter logic [TW-1:0] ORG_CTS_CYC    = TW'((CLK_HZ * T_ORG_CTS_MS + 999) / 1000),
  parameter logic [TW-1:0] BREAK_CYC      = TW'((CLK_HZ * T_BREAK_MS + 999) / 1000),
  parameter logic [TW-1:0] SHORT_SP_CYC   = TW'((CLK_HZ * T_SHORT_SPACE_MS + 999) / 1000),
  parameter logic [TW-1:0] LONG_SP_CYC    = TW'((CLK_HZ * T_LONG_SPACE_MS + 999) / 1000),
  parameter logic [TW-1:0] SUPERVISE_CYC  = TW'(CLK_HZ * T_SUPERVISE_S)
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic incoming_call_in,
  input  wire logic originate_hook_in,
  input  wire logic carrier_level_ok_in,
  input  wire logic rx_in_band_in,
  input  wire logic rx_bit_in,
  input  wire logic tx_bit_in,
  input  wire logic term_ready_n_in,
  input  wire logic break_release_n_in,
  input  wire logic short_space_hangup_en,
  input  wire logic long_space_hangup_en,
  output logic      line_seize_out,
  output logic      mode_out,
  output logic      tx_carrier_on_out,
  output logic      tx_answer_tone_out,
  output logic      tx_bit_out,
  output logic      clear_to_send_n_out,
  output logic      rx_bit_out,
  output logic      rx_break_out
);

  // ==========================================================
  // State record
  // ==========================================================
  typedef struct packed {
    call_state_t   st;
    logic          mode;
    logic          seize;
    logic          tx_on;
    logic          tx_hi;
    logic          cts_n;
    logic          rx_open;
    logic          rx_bit;
    logic          tx_bit;
    logic          brk;
    logic          brk_out;
    logic          ring_prev;
    logic [TW-1:0] low_len;
    logic [TW-1:0] high_len;
    logic [4:0]    cyc;
  } sup_state_t;

  localparam sup_state_t S_RST = '{
    st: ST_IDLE, mode: MODE_ORIGINATE, seize: 1'h0, tx_on: 1'h0,
    tx_hi: 1'h0, cts_n: 1'h1, rx_open: 1'h0, rx_bit: LVL_MARK,
    tx_bit: LVL_MARK, brk: 1'h0, brk_out: 1'h1, ring_prev: 1'h0,
    low_len: '0, high_len: '0, cyc: '0};

  sup_state_t    s_r;
  sup_state_t    s_nxt;
  logic [TM_NUM-1:0] tm_run;
  logic [TW-1:0] tm_cnt [TM_NUM];

  // ==========================================================
  // Duration timers, one per supervised condition
  // ==========================================================
  for (genvar i = 0; i < TM_NUM; i++) begin : g_tmr
    run_timer #(
      .W     (TW)
    ) u_tmr (
      .clock (clock),
      .nrst  (nrst),
      .run   (tm_run[i]),
      .count (tm_cnt[i])
    );
  end

  // ==========================================================
  // Decoded conditions
  // ==========================================================
  logic          ring_low;
  logic [TW-1:0] ring_period;
  logic          ring_cycle_ok;
  logic          ring_hit;
  logic          in_wait;
  logic          in_up;
  logic          td_lost;
  logic          carrier_ok;
  logic          call_released;
  logic          space_hangup;
  logic          sup_expired;

  // Ring low phase and period checks
  assign ring_low      = !incoming_call_in;
  assign ring_period   = s_r.low_len + s_r.high_len;
  assign ring_cycle_ok = (s_r.low_len != '0) && (s_r.low_len >= s_r.high_len)
                      && (ring_period >= RING_PMIN_CYC)
                      && (ring_period <= RING_PMAX_CYC);
  assign ring_hit      = (s_r.low_len >= RING_LOW_CYC)
                      || (s_r.cyc >= RING_CYCLES);

  // Call phases
  assign in_wait = (s_r.st == ST_ANS_WAIT) || (s_r.st == ST_ORG_WAIT);
  assign in_up   = (s_r.st == ST_ANS_UP) || (s_r.st == ST_ORG_UP);

  // Carrier supervision from threshold gaps and frequency window
  assign td_lost    = (tm_cnt[TM_TD] >= TD_LOSS_CYC);
  assign carrier_ok = !td_lost && rx_in_band_in;

  // Ring or hook has been let go by the coupler
  assign call_released = (s_r.mode == MODE_ANSWER) ? incoming_call_in
                                                   : originate_hook_in;
  assign sup_expired   = (tm_cnt[TM_SUP] >= SUPERVISE_CYC);

  // Space disconnect straps, both active low
  assign space_hangup = (!short_space_hangup_en
                         && (tm_cnt[TM_SPACE] >= SHORT_SP_CYC))
                     || (!long_space_hangup_en
                         && (tm_cnt[TM_SPACE] >= LONG_SP_CYC));

  // Timer run conditions
  always_comb begin
    tm_run           = '0;
    tm_run[TM_TD]    = carrier_level_ok_in && (s_r.st != ST_IDLE);
    tm_run[TM_CARR]  = in_up && carrier_ok;
    tm_run[TM_PHASE] = in_up;
    tm_run[TM_SPACE] = in_up && s_r.rx_open && !rx_bit_in;
    tm_run[TM_SUP]   = in_wait && call_released;
  end

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    s_nxt = s_r;
    s_nxt.ring_prev = ring_low;

    // Ring phase measurement, saturating
    if (ring_low) begin
      if (s_r.low_len != {TW{1'b1}}) begin
        s_nxt.low_len = s_r.low_len + TW'(1);
      end
    end else if (s_r.high_len != {TW{1'b1}}) begin
      s_nxt.high_len = s_r.high_len + TW'(1);
    end
    if (ring_low && !s_r.ring_prev) begin
      // A new low phase closes the previous ring cycle
      s_nxt.cyc      = ring_cycle_ok ? s_r.cyc + 5'h01 : 5'h00;
      s_nxt.low_len  = '0;
      s_nxt.high_len = '0;
    end else if (!ring_low && (s_r.high_len > RING_PMAX_CYC)) begin
      s_nxt.cyc = 5'h00;
    end

    // Call sequencing
    case (s_r.st)
      ST_IDLE: begin
        if (ring_hit) begin
          s_nxt.mode = MODE_ANSWER;
          if (!term_ready_n_in) begin
            s_nxt.st    = ST_ANS_WAIT;
            s_nxt.seize = 1'h1;
            s_nxt.tx_on = 1'h1;
            s_nxt.tx_hi = 1'h1;
          end
        end else if (!originate_hook_in) begin
          s_nxt.mode = MODE_ORIGINATE;
          if (!term_ready_n_in) begin
            s_nxt.st    = ST_ORG_WAIT;
            s_nxt.seize = 1'h1;
          end
        end
      end
      ST_ANS_WAIT, ST_ORG_WAIT: begin
        if (sup_expired) begin
          s_nxt.st = ST_IDLE;
        end else if (carrier_ok) begin
          // Remote carrier arrives after its own delay
          s_nxt.st = (s_r.st == ST_ANS_WAIT) ? ST_ANS_UP : ST_ORG_UP;
        end
      end
      ST_ANS_UP, ST_ORG_UP: begin
        if (space_hangup) begin
          s_nxt.st = ST_IDLE;
        end else if (td_lost) begin
          // Carrier lost: drop the handshake and wait for it again
          s_nxt.st      = (s_r.st == ST_ANS_UP) ? ST_ANS_WAIT : ST_ORG_WAIT;
          s_nxt.cts_n   = 1'h1;
          s_nxt.rx_open = 1'h0;
          if (s_r.st == ST_ORG_UP) begin
            s_nxt.tx_on = 1'h0;
          end
        end else begin
          if (tm_cnt[TM_CARR] >= UNCLAMP_CYC) begin
            s_nxt.rx_open = 1'h1;
          end
          if (s_r.st == ST_ANS_UP) begin
            if (tm_cnt[TM_PHASE] >= ANS_CTS_CYC) begin
              s_nxt.cts_n = 1'h0;
            end
          end else begin
            if (tm_cnt[TM_PHASE] >= ORG_TXON_CYC) begin
              s_nxt.tx_on = 1'h1;
              s_nxt.tx_hi = 1'h0;
            end
            if (tm_cnt[TM_PHASE] >= ORG_CTS_CYC) begin
              s_nxt.cts_n = 1'h0;
            end
          end
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // Any return to idle from a call is a hang-up
    if ((s_nxt.st == ST_IDLE) && (s_r.st != ST_IDLE)) begin
      s_nxt.seize    = 1'h0;
      s_nxt.tx_on    = 1'h0;
      s_nxt.tx_hi    = 1'h0;
      s_nxt.cts_n    = 1'h1;
      s_nxt.rx_open  = 1'h0;
      s_nxt.mode     = MODE_ORIGINATE;
      s_nxt.low_len  = '0;
      s_nxt.high_len = '0;
      s_nxt.cyc      = 5'h00;
    end

    // Receive break: the set wins over a release in the same cycle
    if (tm_cnt[TM_SPACE] >= BREAK_CYC) begin
      s_nxt.brk = 1'h1;
    end else if (!break_release_n_in) begin
      s_nxt.brk = 1'h0;
    end
    s_nxt.brk_out = s_nxt.brk || s_nxt.cts_n;

    // Data clamps follow the next handshake state
    s_nxt.rx_bit = s_nxt.rx_open ? rx_bit_in : LVL_MARK;
    s_nxt.tx_bit = s_nxt.cts_n ? LVL_MARK : tx_bit_in;
  end

  // State register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  // ==========================================================
  assign line_seize_out      = s_r.seize;
  assign mode_out            = s_r.mode;
  assign tx_carrier_on_out   = s_r.tx_on;
  assign tx_answer_tone_out  = s_r.tx_hi;
  assign tx_bit_out          = s_r.tx_bit;
  assign clear_to_send_n_out = s_r.cts_n;
  assign rx_bit_out          = s_r.rx_bit;
  assign rx_break_out        = s_r.brk_out;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence seq_idle_ring_ready;
    (s_r.st == ST_IDLE) && ring_hit && !term_ready_n_in;
  endsequence

  sequence seq_line_released;
    !line_seize_out && clear_to_send_n_out && !tx_carrier_on_out;
  endsequence

  chk_ring_seizes_line: assert property (
    seq_idle_ring_ready |=> line_seize_out && (mode_out == MODE_ANSWER))
    else $error("ring with terminal ready did not seize line");

  chk_answer_tone_on: assert property (
    (s_r.st == ST_ANS_WAIT) |-> tx_carrier_on_out && tx_answer_tone_out)
    else $error("answer tone not on while answering");

  chk_carrier_loss: assert property (
    in_up && td_lost |=> clear_to_send_n_out && !in_up)
    else $error("carrier loss did not drop clear to send");

  chk_unclamp_time: assert property (
    $rose(s_r.rx_open) |-> $past(tm_cnt[TM_CARR]) >= UNCLAMP_CYC)
    else $error("received data unclamped too early");

  chk_ans_cts_time: assert property (
    $fell(clear_to_send_n_out) && (mode_out == MODE_ANSWER)
      |-> tm_cnt[TM_PHASE] > ANS_CTS_CYC)
    else $error("answer clear to send too early");

  chk_tx_clamped: assert property (
    clear_to_send_n_out |-> tx_bit_out == LVL_MARK)
    else $error("transmit data not clamped to mark");

  chk_break_set: assert property (
    (tm_cnt[TM_SPACE] >= BREAK_CYC)
      |=> rx_break_out ##1 (rx_break_out || !$past(break_release_n_in)))
    else $error("long space did not set receive break");

  chk_short_space: assert property (
    in_up && !short_space_hangup_en && (tm_cnt[TM_SPACE] >= SHORT_SP_CYC)
      |=> seq_line_released)
    else $error("short space did not hang up");

  chk_supervise_end: assert property (
    in_wait && sup_expired |=> seq_line_released)
    else $error("handshake timeout did not hang up");

  chk_org_txon: assert property (
    $rose(tx_carrier_on_out) && (mode_out == MODE_ORIGINATE)
      |-> tm_cnt[TM_PHASE] > ORG_TXON_CYC && !tx_answer_tone_out)
    else $error("originate carrier started too early");

  chk_org_cts_time: assert property (
    $fell(clear_to_send_n_out) && (mode_out == MODE_ORIGINATE)
      |-> tm_cnt[TM_PHASE] > ORG_CTS_CYC)
    else $error("originate clear to send too early");

  chk_hangup_clamps: assert property (
    $fell(line_seize_out) |-> seq_line_released and rx_bit_out == LVL_MARK)
    else $error("hang-up left line state active");

endmodule : fsk_modem_supervisory_control

// File: include/fsk_sup_pkg.sv
// Shared constants and types of the FSK modem supervisory control
package fsk_sup_pkg;

  // ==========================================================
  // Reference clock and documented times, in their own units
  // ==========================================================
  localparam longint CLK_HZ           = 125_000_000;
  localparam longint T_RING_LOW_MS    = 51;
  localparam longint RING_FMIN_HZ     = 20;
  localparam longint RING_FMAX_HZ     = 47;
  localparam longint T_TD_LOSS_MS     = 51;
  localparam longint T_UNCLAMP_MS     = 150;
  localparam longint T_ANS_CTS_MS     = 450;
  localparam longint T_ORG_TXON_MS    = 450;
  localparam longint T_ORG_CTS_MS     = 750;
  localparam longint T_BREAK_MS       = 150;
  localparam longint T_SHORT_SPACE_MS = 300;
  localparam longint T_LONG_SPACE_MS  = 1500;
  localparam longint T_SUPERVISE_S    = 17;

  // Ringing cycles needed for an alternating ring signal
  localparam logic [4:0] RING_CYCLES = 5'h14;

  // ==========================================================
  // Counter widths and timer slots
  // ==========================================================
  localparam int TW       = 32;
  localparam int TM_TD    = 0;
  localparam int TM_CARR  = 1;
  localparam int TM_PHASE = 2;
  localparam int TM_SPACE = 3;
  localparam int TM_SUP   = 4;
  localparam int TM_NUM   = 5;

  // ==========================================================
  // Line levels
  // ==========================================================
  localparam logic MODE_ANSWER    = 1'h0;
  localparam logic MODE_ORIGINATE = 1'h1;
  localparam logic LVL_MARK       = 1'h1;

  // ==========================================================
  // Call states
  // ==========================================================
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ANS_WAIT = 3'b001,
    ST_ANS_UP   = 3'b010,
    ST_ORG_WAIT = 3'b011,
    ST_ORG_UP   = 3'b100
  } call_state_t;

endpackage : fsk_sup_pkg

// File: logic/run_timer.sv
// Saturating duration counter that runs while its condition holds
module run_timer
  import fsk_sup_pkg::*;
#(
  parameter int W = TW
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         run,
  output logic      [W-1:0] count
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_state_t;

  tmr_state_t s_r;
  tmr_state_t s_nxt;

  // Count up while running, clear when the condition drops
  always_comb begin
    s_nxt = s_r;
    if (!run) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt != {W{1'b1}}) begin
      s_nxt.cnt = s_r.cnt + W'(1);
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign count = s_r.cnt;

endmodule : run_timer

// File: sim/remote_line_model.sv
// Far-side model: remote modem carrier, threshold detector and demodulator output
module remote_line_model #(
  parameter int PULSE_GAP = 16
) (
  input  wire logic clock,
  input  wire logic carrier_en,
  input  wire logic data_bit,
  output logic      carrier_level_ok_in,
  output logic      rx_in_band_in,
  output logic      rx_bit_in
);
  timeunit 1ns;
  timeprecision 1ps;

  int   gap_cnt;
  logic junk_r;

  // ==========================================================
  // Idle levels at time zero
  // ==========================================================
  initial begin
    gap_cnt             = 0;
    junk_r              = 1'h0;
    carrier_level_ok_in = 1'h1;
    rx_in_band_in       = 1'h0;
    rx_bit_in           = 1'h1;
  end

  // ==========================================================
  // Line behaviour, changed at the falling edge
  // ==========================================================
  // Threshold pulses low once per PULSE_GAP cycles while carrier is present
  always @(negedge clock) begin
    junk_r <= ~junk_r;
    if (!carrier_en) begin
      gap_cnt             <= 0;
      carrier_level_ok_in <= 1'h1;
    end else begin
      gap_cnt             <= (gap_cnt == PULSE_GAP - 1) ? 0 : gap_cnt + 1;
      carrier_level_ok_in <= (gap_cnt == 0) ? 1'h0 : 1'h1;
    end
    rx_in_band_in <= carrier_en;
    // Without carrier the data line carries no stable value
    rx_bit_in     <= carrier_en ? data_bit : junk_r;
  end
endmodule : remote_line_model

// File: sim/tb_top.sv
// Self-checking testbench of the FSK modem supervisory control
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'h0;
  logic nrst, ring_n, hook_n, term_n, txb, brk_n, ess_n, els_n, carrier_en, data_bit;
  logic td_n, in_band, rxb;
  logic seize, mode, tx_on, tone, tx_bit, cts_n, rx_bit, rx_brk;
  int   n_fail      = 0;
  int   check_count = 0;

  // ==========================================================
  // Clock, design and far side
  // ==========================================================
  always #4 clock = ~clock;

  // Scaled timing counts handed to the design, orderings as the defaults except RING_LOW_T below RING_PMAX_T, and TD_LOSS_T below both
  localparam logic [31:0] RING_LOW_T  = 32'h32;
  localparam logic [31:0] RING_PMIN_T = 32'h14;
  localparam logic [31:0] RING_PMAX_T = 32'h3C;
  localparam logic [31:0] TD_LOSS_T   = 32'h28;
  localparam logic [31:0] UNCLAMP_T   = 32'h64;
  localparam logic [31:0] ANS_CTS_T   = 32'h12C;
  localparam logic [31:0] ORG_TXON_T  = 32'h12C;
  localparam logic [31:0] ORG_CTS_T   = 32'h1F4;
  localparam logic [31:0] BREAK_T     = 32'h64;
  localparam logic [31:0] SHORT_SP_T  = 32'hC8;
  localparam logic [31:0] LONG_SP_T   = 32'h3E8;
  localparam logic [31:0] SUPERVISE_T = 32'h7D0;

  fsk_modem_supervisory_control #(
    .RING_LOW_CYC (RING_LOW_T), .RING_PMIN_CYC(RING_PMIN_T), .RING_PMAX_CYC(RING_PMAX_T),
    .TD_LOSS_CYC  (TD_LOSS_T), .UNCLAMP_CYC  (UNCLAMP_T), .ANS_CTS_CYC  (ANS_CTS_T),
    .ORG_TXON_CYC (ORG_TXON_T), .ORG_CTS_CYC (ORG_CTS_T), .BREAK_CYC   (BREAK_T),
    .SHORT_SP_CYC (SHORT_SP_T), .LONG_SP_CYC  (LONG_SP_T), .SUPERVISE_CYC(SUPERVISE_T)
  ) i_fsk_modem_supervisory_control (
    .clock(clock), .nrst(nrst), .incoming_call_in(ring_n), .originate_hook_in(hook_n),
    .carrier_level_ok_in(td_n), .rx_in_band_in(in_band), .rx_bit_in(rxb),
    .tx_bit_in(txb), .term_ready_n_in(term_n), .break_release_n_in(brk_n),
    .short_space_hangup_en(ess_n), .long_space_hangup_en(els_n),
    .line_seize_out(seize), .mode_out(mode), .tx_carrier_on_out(tx_on),
    .tx_answer_tone_out(tone), .tx_bit_out(tx_bit), .clear_to_send_n_out(cts_n),
    .rx_bit_out(rx_bit), .rx_break_out(rx_brk)
  );

  remote_line_model i_remote_line_model (
    .clock(clock), .carrier_en(carrier_en), .data_bit(data_bit),
    .carrier_level_ok_in(td_n), .rx_in_band_in(in_band), .rx_bit_in(rxb)
  );

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  task automatic check(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check

  // Carrier arrives with space data: clamped first, then passed through
  task automatic handshake_rx;
    data_bit   <= 1'h0;
    carrier_en <= 1'h1;
    tick(90);
    check("rx_bit clamped", 1'h1, rx_bit);
    tick(25);
    check("rx_bit released", 1'h0, rx_bit);
    data_bit <= 1'h1;
  endtask : handshake_rx

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // ==========================================================
  // Watchdog against a hang
  // ==========================================================
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("[FAIL] watchdog expected done seen timeout");
    final_report();
  end

  // ==========================================================
  // Test sequence
  // ==========================================================
  initial begin
    nrst = 1'h0; ring_n = 1'h1; hook_n = 1'h1; term_n = 1'h1; txb = 1'h1;
    brk_n = 1'h1; ess_n = 1'h1; els_n = 1'h1; carrier_en = 1'h0; data_bit = 1'h1;
    tick(3);
    nrst <= 1'h1;
    tick(1);
    check("seize idle", 1'h0, seize);
    check("mode idle", 1'h1, mode);
    check("cts_n idle", 1'h1, cts_n);
    check("rx_bit idle", 1'h1, rx_bit);
    check("rx_brk idle", 1'h1, rx_brk);
    check("tx_on idle", 1'h0, tx_on);
    check("tone idle", 1'h0, tone);
    check("tx_bit idle", 1'h1, tx_bit);
    // Answer call: ring held low, terminal not ready at first
    ring_n <= 1'h0;
    tick(45);
    check("mode short ring", 1'h1, mode);
    tick(15);
    check("mode answer", 1'h0, mode);
    check("seize not ready", 1'h0, seize);
    term_n <= 1'h0;                        // Stays ready, no disconnect request
    tick(3);
    check("seize ready", 1'h1, seize);
    check("tx_on answer", 1'h1, tx_on);
    check("tone answer", 1'h1, tone);
    ring_n <= 1'h1;
    tick(300);
    handshake_rx();
    txb <= 1'h0;
    tick(175);
    check("cts_n early", 1'h1, cts_n);
    check("tx_bit clamped", 1'h1, tx_bit);
    tick(25);
    check("cts_n answer", 1'h0, cts_n);
    check("tx_bit passed", 1'h0, tx_bit);
    check("rx_brk clear", 1'h0, rx_brk);
    txb <= 1'h1;
    // Receive break set by long space, kept, then released
    data_bit <= 1'h0;
    tick(110);
    check("rx_brk set", 1'h1, rx_brk);
    data_bit <= 1'h1;
    tick(20);
    check("rx_brk held", 1'h1, rx_brk);
    brk_n <= 1'h0;
    tick(2);
    brk_n <= 1'h1;
    tick(2);
    check("rx_brk released", 1'h0, rx_brk);
    // Short space hang-up
    ess_n    <= 1'h0;
    data_bit <= 1'h0;
    tick(190);
    check("seize short sp", 1'h1, seize);
    tick(20);
    check("seize hung up", 1'h0, seize);
    check("tx_on hung up", 1'h0, tx_on);
    check("cts_n hung up", 1'h1, cts_n);
    check("rx_bit hung up", 1'h1, rx_bit);
    ess_n <= 1'h1; carrier_en <= 1'h0; data_bit <= 1'h1;
    tick(5);
    // Originate call
    hook_n <= 1'h0;
    tick(2);
    check("mode originate", 1'h1, mode);
    check("seize originate", 1'h1, seize);
    check("tx_on wait", 1'h0, tx_on);
    hook_n <= 1'h1;
    tick(20);
    handshake_rx();
    tick(175);
    check("tx_on early", 1'h0, tx_on);
    tick(25);
    check("tx_on mark", 1'h1, tx_on);
    check("tone mark", 1'h0, tone);
    tick(175);
    check("cts_n early", 1'h1, cts_n);
    tick(25);
    check("cts_n originate", 1'h0, cts_n);
    // Carrier loss, then supervision timeout
    carrier_en <= 1'h0;
    tick(30);
    check("cts_n short gap", 1'h0, cts_n);
    tick(20);
    check("cts_n loss", 1'h1, cts_n);
    check("tx_on loss", 1'h0, tx_on);
    tick(1850);
    check("seize supervise", 1'h1, seize);
    tick(200);
    check("seize timeout", 1'h0, seize);
    // Second originate call ended by long space
    hook_n <= 1'h0;
    tick(2);
    hook_n <= 1'h1; els_n <= 1'h0; data_bit <= 1'h0; carrier_en <= 1'h1;
    tick(1050);
    check("seize long sp", 1'h1, seize);
    tick(80);
    check("seize long end", 1'h0, seize);
    els_n <= 1'h1; carrier_en <= 1'h0; data_bit <= 1'h1;
    // Alternating ring: 20 closed cycles of 20 low, 15 high are needed
    for (int i = 0; i < 21; i++) begin
      if (i == 20) begin
        check("seize 19 rings", 1'h0, seize);
        check("mode 19 rings", 1'h1, mode);
      end
      ring_n <= 1'h0;
      tick(20);
      ring_n <= 1'h1;
      tick(15);
    end
    check("seize 20 rings", 1'h1, seize);
    check("mode 20 rings", 1'h0, mode);
    check("tone 20 rings", 1'h1, tone);
    // Reset in mid-call drops the line
    nrst <= 1'h0;
    tick(3);
    nrst <= 1'h1;
    tick(1);
    check("seize reset", 1'h0, seize);
    check("mode reset", 1'h1, mode);
    check("tone reset", 1'h0, tone);
    check("cts_n reset", 1'h1, cts_n);
    final_report();
  end
endmodule : tb_top
